/* File: logic/lic_gain_decode.sv */
// Purpose: turns a two-bit monitor gain code into attenuation and mute
// Assumes: code 3 always mutes
// Notes: attenuation in dB below unity, positive number
`timescale 1ns/10ps
`include "lic_map.svh"
module lic_gain_decode #(
  parameter logic [5:0] BASE_DB = 6'd0
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [1:0] code_in,
  output logic [5:0] atten_db_out,
  output logic mute_out
);
  logic [5:0] atten_next;
  logic mute_next;

  // ==========================================================================
  // base plus six dB per step; muted code still gives base plus three steps (18 dB)
  always_comb begin
    atten_next = BASE_DB + 6'(`LIC_STEP_DB * {4'h0, code_in});
    mute_next = (code_in == `LIC_GAIN_MUTE);
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      atten_db_out <= 6'h00;
      mute_out <= 1'b1;
    end else begin
      atten_db_out <= atten_next;
      mute_out <= mute_next;
    end
  end
endmodule

/* File: logic/lic_hook_timer.sv */
// Purpose: times the on-hook release that a hook register write starts
// Assumes: load_in is a one-cycle pulse on each hook register write
// Notes: a new write restarts the count with the new speed
`timescale 1ns/10ps
module lic_hook_timer #(
  parameter int unsigned FAST_CYC = 100000,
  parameter int unsigned MID_CYC = 600000,
  parameter int unsigned SLOW_CYC = 4000000,
  parameter int unsigned CNT_W = 23
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic load_in,
  input wire logic [1:0] speed_in,
  output logic busy_out
);
  lic_pkg::lic_rel_state_e state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;

  // ==========================================================================
  // count down from the selected time; upper speed bit alone picks the slow one
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (load_in) begin
      state_next = lic_pkg::REL_BUSY;
      if (speed_in[1]) begin
        cnt_next = CNT_W'(SLOW_CYC - 1);
      end else if (speed_in[0]) begin
        cnt_next = CNT_W'(MID_CYC - 1);
      end else begin
        cnt_next = CNT_W'(FAST_CYC - 1);
      end
    end else begin
      case (state_reg)
        lic_pkg::REL_IDLE: begin
          cnt_next = '0;
        end
        lic_pkg::REL_BUSY: begin
          if (cnt_reg == '0) begin
            state_next = lic_pkg::REL_IDLE;
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        default: begin
          state_next = lic_pkg::REL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= lic_pkg::REL_IDLE;
      cnt_reg <= '0;
      busy_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      busy_out <= (state_next == lic_pkg::REL_BUSY);
    end
  end
endmodule

/* File: logic/lic_map.svh */
// Purpose: addresses, reset values, field positions and figures of the line interface bank
// Assumes: included by bare name; definitions only
// Notes: byte addresses on a 32-bit AHB-Lite bus, one word per register
`ifndef LIC_MAP_SVH
`define LIC_MAP_SVH

// ==========================================================================
// register addresses and reset values
`define LIC_OFS_GAIN 12'h000
`define LIC_OFS_HOOK 12'h004
`define LIC_OFS_LOOP 12'h008
`define LIC_GAIN_RST 8'h0f
`define LIC_HOOK_RST 8'h00
`define LIC_LOOP_RST 8'hf0
`define LIC_GAIN_RMASK 8'h0f
`define LIC_HOOK_RMASK 8'h3f

// ==========================================================================
// field positions
`define LIC_RXG_MSB 3
`define LIC_RXG_LSB 2
`define LIC_TXG_MSB 1
`define LIC_TXG_LSB 0
`define LIC_OHS_MSB 5
`define LIC_OHS_LSB 4
`define LIC_CAP_BIT 3
`define LIC_RZ_BIT 2
`define LIC_RT_BIT 0
`define LIC_MINI_MSB 7
`define LIC_MINI_LSB 6
`define LIC_DCV_MSB 5
`define LIC_DCV_LSB 4
`define LIC_ACT_MSB 3
`define LIC_ACT_LSB 0

// ==========================================================================
// analog figures as codes
`define LIC_GAIN_MUTE 2'b11
`define LIC_RX_BASE_DB 6'd0
`define LIC_TX_BASE_DB 6'd18
`define LIC_STEP_DB 6'd6
`define LIC_MINI_BASE_MA 5'd10
`define LIC_MINI_STEP_MA 5'd2
`define LIC_CAP_MA 7'd60
`define LIC_NO_CAP_MA 7'd0
`define LIC_DCT_MV0 12'd3100
`define LIC_DCT_MV1 12'd3200
`define LIC_DCT_MV2 12'd3350
`define LIC_DCT_MV3 12'd3500
`define LIC_RING_LO0_CV 12'd1350
`define LIC_RING_HI0_CV 12'd1650
`define LIC_RING_LO1_CV 12'd1935
`define LIC_RING_HI1_CV 12'd2365
`define LIC_ACT_REAL600 4'h0
`define LIC_ACT_COMPLEX 4'h3

// ==========================================================================
// timing
`define LIC_CLK_KHZ 200000
`define LIC_HOOK_FAST_MS 0.5
`define LIC_HOOK_MID_MS 3
`define LIC_HOOK_SLOW_MS 20

// ==========================================================================
// bus codes
`define LIC_HTRANS_NONSEQ 2'b10
`define LIC_HRESP_OKAY 1'b0

`endif

/* File: logic/lic_pkg.sv */
// Purpose: shared types of the line interface bank
// Assumes: nothing
// Notes: constants live in lic_map.svh
package lic_pkg;
  // ==========================================================================
  // release timer states
  typedef enum logic {
    REL_IDLE,
    REL_BUSY
  } lic_rel_state_e;

  // register select decoded from the bus address
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_GAIN,
    SEL_HOOK,
    SEL_LOOP
  } lic_sel_e;
endpackage

/* File: logic/lic_regs.sv */
// Purpose: line interface configuration bank on an AHB-Lite slave
// Assumes: single master, zero wait states, whole-word transfers
// Notes: settings leave as fields and as decoded figures, all registered
// ==========================================================================
`timescale 1ns/10ps
`include "lic_map.svh"
module lic_regs #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned HOOK_FAST_CYC = int'(`LIC_HOOK_FAST_MS * `LIC_CLK_KHZ),
  parameter int unsigned HOOK_MID_CYC = `LIC_HOOK_MID_MS * `LIC_CLK_KHZ,
  parameter int unsigned HOOK_SLOW_CYC = `LIC_HOOK_SLOW_MS * `LIC_CLK_KHZ
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  output logic [5:0] rx_gain_atten_db_out,
  output logic rx_gain_mute_out,
  output logic [5:0] tx_gain_atten_db_out,
  output logic tx_gain_mute_out,
  output logic [1:0] hook_release_speed_out,
  output logic loop_release_busy_out,
  output logic loop_current_cap_en_out,
  output logic [6:0] loop_current_cap_ma_out,
  output logic ringer_impedance_sel_out,
  output logic ring_threshold_sel_out,
  output logic [11:0] ring_window_lo_cv_out,
  output logic [11:0] ring_window_hi_cv_out,
  output logic [1:0] min_loop_current_out,
  output logic [4:0] min_loop_current_ma_out,
  output logic [1:0] line_voltage_adjust_out,
  output logic [11:0] line_dc_control_pin_mv_out,
  output logic [3:0] ac_termination_sel_out,
  output logic ac_term_real600_out,
  output logic ac_term_complex_out
);
  // ==========================================================================
  // state
  logic [7:0] gain_reg, gain_next;
  logic [7:0] hook_reg, hook_next;
  logic [7:0] loop_reg, loop_next;
  lic_pkg::lic_sel_e wsel_reg, wsel_next;
  logic [31:0] rdata_reg, rdata_next;
  logic hook_wr_reg, hook_wr_next;
  logic [6:0] cap_ma_reg, cap_ma_next;
  logic [11:0] ring_lo_reg, ring_lo_next;
  logic [11:0] ring_hi_reg, ring_hi_next;
  logic [4:0] mini_ma_reg, mini_ma_next;
  logic [11:0] dct_mv_reg, dct_mv_next;
  logic real600_reg, real600_next;
  logic complex_reg, complex_next;
  logic addr_take;
  lic_pkg::lic_sel_e asel;

  // address to register select; unmapped words give SEL_NONE
  function automatic lic_pkg::lic_sel_e lic_decode(input logic [ADDR_W-1:0] addr);
    lic_decode = lic_pkg::SEL_NONE;
    if (addr == ADDR_W'(`LIC_OFS_GAIN)) begin
      lic_decode = lic_pkg::SEL_GAIN;
    end else if (addr == ADDR_W'(`LIC_OFS_HOOK)) begin
      lic_decode = lic_pkg::SEL_HOOK;
    end else if (addr == ADDR_W'(`LIC_OFS_LOOP)) begin
      lic_decode = lic_pkg::SEL_LOOP;
    end
  endfunction

  // ==========================================================================
  // bus slave: address phase captured, write lands in the data phase
  always_comb begin
    addr_take = hsel_in && hready_in && htrans_in[1] && !hsize_in[2];
    asel = addr_take ? lic_decode(haddr_in) : lic_pkg::SEL_NONE;
    wsel_next = (addr_take && hwrite_in) ? asel : lic_pkg::SEL_NONE;
    gain_next = gain_reg;
    hook_next = hook_reg;
    loop_next = loop_reg;
    hook_wr_next = 1'b0;
    case (wsel_reg)
      lic_pkg::SEL_GAIN: begin
        gain_next = hwdata_in[7:0] & `LIC_GAIN_RMASK;
      end
      lic_pkg::SEL_HOOK: begin
        hook_next = hwdata_in[7:0] & `LIC_HOOK_RMASK;
        hook_wr_next = 1'b1;
      end
      lic_pkg::SEL_LOOP: begin
        loop_next = hwdata_in[7:0];
      end
      default: begin
        hook_wr_next = 1'b0;
      end
    endcase
    // read data from next values so a read right behind a write sees it
    rdata_next = 32'h0000_0000;
    if (addr_take && !hwrite_in) begin
      case (asel)
        lic_pkg::SEL_GAIN: rdata_next = {24'h00_0000, gain_next};
        lic_pkg::SEL_HOOK: rdata_next = {24'h00_0000, hook_next};
        lic_pkg::SEL_LOOP: rdata_next = {24'h00_0000, loop_next};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // reset values make both gain paths muted and the loop fields at highest codes, except AC termination at code 0
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gain_reg <= `LIC_GAIN_RST;
      hook_reg <= `LIC_HOOK_RST;
      loop_reg <= `LIC_LOOP_RST;
      wsel_reg <= lic_pkg::SEL_NONE;
      rdata_reg <= 32'h0000_0000;
      hook_wr_reg <= 1'b0;
    end else begin
      gain_reg <= gain_next;
      hook_reg <= hook_next;
      loop_reg <= loop_next;
      wsel_reg <= wsel_next;
      rdata_reg <= rdata_next;
      hook_wr_reg <= hook_wr_next;
    end
  end

  assign hrdata_out = rdata_reg;
  // zero wait states; both fixed outputs are constant flops in effect
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= `LIC_HRESP_OKAY;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= `LIC_HRESP_OKAY;
    end
  end

  // ==========================================================================
  // field outputs straight from the stored bits
  assign hook_release_speed_out = hook_reg[`LIC_OHS_MSB:`LIC_OHS_LSB];
  assign loop_current_cap_en_out = hook_reg[`LIC_CAP_BIT];
  assign ringer_impedance_sel_out = hook_reg[`LIC_RZ_BIT];
  assign ring_threshold_sel_out = hook_reg[`LIC_RT_BIT];
  assign min_loop_current_out = loop_reg[`LIC_MINI_MSB:`LIC_MINI_LSB];
  assign line_voltage_adjust_out = loop_reg[`LIC_DCV_MSB:`LIC_DCV_LSB];
  assign ac_termination_sel_out = loop_reg[`LIC_ACT_MSB:`LIC_ACT_LSB];

  // ==========================================================================
  // decoded analog figures, one cycle behind the fields
  always_comb begin
    cap_ma_next = hook_reg[`LIC_CAP_BIT] ? `LIC_CAP_MA : `LIC_NO_CAP_MA;
    ring_lo_next = hook_reg[`LIC_RT_BIT] ? `LIC_RING_LO1_CV : `LIC_RING_LO0_CV;
    ring_hi_next = hook_reg[`LIC_RT_BIT] ? `LIC_RING_HI1_CV : `LIC_RING_HI0_CV;
    mini_ma_next = `LIC_MINI_BASE_MA
      + 5'(`LIC_MINI_STEP_MA * {3'h0, loop_reg[`LIC_MINI_MSB:`LIC_MINI_LSB]});
    case (loop_reg[`LIC_DCV_MSB:`LIC_DCV_LSB])
      2'b00: dct_mv_next = `LIC_DCT_MV0;
      2'b01: dct_mv_next = `LIC_DCT_MV1;
      2'b10: dct_mv_next = `LIC_DCT_MV2;
      default: dct_mv_next = `LIC_DCT_MV3;
    endcase
    // other termination codes select neither documented network
    real600_next = (loop_reg[`LIC_ACT_MSB:`LIC_ACT_LSB] == `LIC_ACT_REAL600);
    complex_next = (loop_reg[`LIC_ACT_MSB:`LIC_ACT_LSB] == `LIC_ACT_COMPLEX);
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cap_ma_reg <= `LIC_NO_CAP_MA;
      ring_lo_reg <= `LIC_RING_LO0_CV;
      ring_hi_reg <= `LIC_RING_HI0_CV;
      mini_ma_reg <= `LIC_MINI_BASE_MA;
      dct_mv_reg <= `LIC_DCT_MV0;
      real600_reg <= 1'b0;
      complex_reg <= 1'b0;
    end else begin
      cap_ma_reg <= cap_ma_next;
      ring_lo_reg <= ring_lo_next;
      ring_hi_reg <= ring_hi_next;
      mini_ma_reg <= mini_ma_next;
      dct_mv_reg <= dct_mv_next;
      real600_reg <= real600_next;
      complex_reg <= complex_next;
    end
  end

  assign loop_current_cap_ma_out = cap_ma_reg;
  assign ring_window_lo_cv_out = ring_lo_reg;
  assign ring_window_hi_cv_out = ring_hi_reg;
  assign min_loop_current_ma_out = mini_ma_reg;
  assign line_dc_control_pin_mv_out = dct_mv_reg;
  assign ac_term_real600_out = real600_reg;
  assign ac_term_complex_out = complex_reg;

  // ==========================================================================
  // monitor gain decoders and hook release timer
  lic_gain_decode #(.BASE_DB(`LIC_RX_BASE_DB)) u_rx_gain (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .code_in(gain_reg[`LIC_RXG_MSB:`LIC_RXG_LSB]),
    .atten_db_out(rx_gain_atten_db_out),
    .mute_out(rx_gain_mute_out)
  );

  lic_gain_decode #(.BASE_DB(`LIC_TX_BASE_DB)) u_tx_gain (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .code_in(gain_reg[`LIC_TXG_MSB:`LIC_TXG_LSB]),
    .atten_db_out(tx_gain_atten_db_out),
    .mute_out(tx_gain_mute_out)
  );

  // release starts on the write itself, not on a change of value
  lic_hook_timer #(
    .FAST_CYC(HOOK_FAST_CYC),
    .MID_CYC(HOOK_MID_CYC),
    .SLOW_CYC(HOOK_SLOW_CYC),
    .CNT_W(23)
  ) u_hook_timer (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .load_in(hook_wr_reg),
    .speed_in(hook_reg[`LIC_OHS_MSB:`LIC_OHS_LSB]),
    .busy_out(loop_release_busy_out)
  );

  // ==========================================================================
  // checks
  logic seen_reg;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= 1'b1;
    end
  end

  rx_gain_map_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    seen_reg |-> (rx_gain_mute_out == ($past(gain_reg[3:2]) == `LIC_GAIN_MUTE))
      && (rx_gain_mute_out || rx_gain_atten_db_out == 6'(`LIC_STEP_DB * $past(gain_reg[3:2]))))
    else $error("rx monitor gain does not follow its code");

  tx_gain_map_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    seen_reg |-> (tx_gain_mute_out == ($past(gain_reg[1:0]) == `LIC_GAIN_MUTE))
      && (tx_gain_mute_out || tx_gain_atten_db_out
        == 6'(`LIC_TX_BASE_DB + `LIC_STEP_DB * $past(gain_reg[1:0]))))
    else $error("tx monitor gain does not follow its code");

  reset_values_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !seen_reg |-> gain_reg == `LIC_GAIN_RST && loop_reg == `LIC_LOOP_RST)
    else $error("bank reset values wrong");

  gain_read_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (addr_take && !hwrite_in && asel == lic_pkg::SEL_GAIN) |=> hrdata_out[31:4] == 28'h0)
    else $error("gain register reserved bits not zero");

  release_start_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    hook_wr_reg |=> loop_release_busy_out [*2])
    else $error("hook write did not start the release");

  cap_value_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    seen_reg |-> loop_current_cap_ma_out == ($past(hook_reg[3]) ? `LIC_CAP_MA : `LIC_NO_CAP_MA))
    else $error("loop current cap figure wrong");

  ringer_write_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    wsel_reg == lic_pkg::SEL_HOOK |=> ringer_impedance_sel_out == $past(hwdata_in[2]))
    else $error("ringer impedance bit not written");

  ring_window_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    seen_reg |-> ring_window_hi_cv_out
      == ($past(hook_reg[0]) ? `LIC_RING_HI1_CV : `LIC_RING_HI0_CV))
    else $error("ring window wrong");

  min_current_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    seen_reg |-> min_loop_current_ma_out
      == 5'(`LIC_MINI_BASE_MA + `LIC_MINI_STEP_MA * $past(loop_reg[7:6])))
    else $error("minimum loop current wrong");

  dc_pin_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (seen_reg && $past(loop_reg[5:4]) == 2'b10) |-> line_dc_control_pin_mv_out == `LIC_DCT_MV2)
    else $error("line dc control pin voltage wrong");

  ac_term_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    seen_reg |-> ac_term_complex_out == ($past(loop_reg[3:0]) == `LIC_ACT_COMPLEX))
    else $error("complex termination flag wrong");

  loop_write_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    wsel_reg == lic_pkg::SEL_LOOP |=> loop_reg == $past(hwdata_in[7:0]))
    else $error("loop register write lost");
endmodule

/* File: tb/tb_lic_regs.sv */
// Purpose: self-checking bench of the line interface register bank
// Assumes: hreadyout feeds the bus hready; release counts shortened to 5/10/20
// Notes: bus answers are copied on the falling edge so edge-time reads never race
`timescale 1ns/10ps
`include "lic_map.svh"
module tb_lic_regs;
  localparam int unsigned FAST = 5;
  localparam int unsigned MID = 10;
  localparam int unsigned SLOW = 20;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdback;
  } lic_row_s;

  // ==========================================================================
  // signals and instance
  logic clk_sys_in, rstn_in, hsel, hwrite, hready, hresp, rdy_n;
  logic [11:0] haddr;
  logic [1:0] htrans, spd, mini, dcv;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd_n, q;
  logic [5:0] rx_db, tx_db;
  logic rx_mute, tx_mute, busy, cap_en, rz, rt, real600, cplx;
  logic [6:0] cap_ma;
  logic [11:0] lo_cv, hi_cv, mv;
  logic [4:0] mini_ma;
  logic [3:0] act;
  logic [7:0] g, h, l;
  lic_row_s r;
  int err_count, checked, n, w;

  lic_regs #(.HOOK_FAST_CYC(FAST), .HOOK_MID_CYC(MID), .HOOK_SLOW_CYC(SLOW)) dut (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
    .rx_gain_atten_db_out(rx_db), .rx_gain_mute_out(rx_mute),
    .tx_gain_atten_db_out(tx_db), .tx_gain_mute_out(tx_mute),
    .hook_release_speed_out(spd), .loop_release_busy_out(busy),
    .loop_current_cap_en_out(cap_en), .loop_current_cap_ma_out(cap_ma),
    .ringer_impedance_sel_out(rz), .ring_threshold_sel_out(rt),
    .ring_window_lo_cv_out(lo_cv), .ring_window_hi_cv_out(hi_cv),
    .min_loop_current_out(mini), .min_loop_current_ma_out(mini_ma),
    .line_voltage_adjust_out(dcv), .line_dc_control_pin_mv_out(mv),
    .ac_termination_sel_out(act), .ac_term_real600_out(real600),
    .ac_term_complex_out(cplx));

  // ==========================================================================
  // clock and mid-cycle copies of the bus answer
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // a copy taken half a cycle early equals what the next rising edge samples
  always @(negedge clk_sys_in) begin
    rdy_n = hready;
    rd_n = hrdata;
  end

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // waits as long as the slave stalls; only the watchdog ends a hang
  task automatic wait_ready();
    do begin
      @(posedge clk_sys_in);
    end while (rdy_n !== 1'b1);
  endtask

  // one single word transfer; junk in the upper bytes must never be stored
  task automatic bus(input logic [11:0] a, input logic wr, input logic [7:0] d,
                     output logic [31:0] rq);
    haddr <= a;
    hwrite <= wr;
    htrans <= `LIC_HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'ha5a5a5, d};
    wait_ready();
    rq = rd_n;
  endtask

  // decoded figures lag the register by a clock, so look mid-cycle later on
  task automatic check_out(input logic [7:0] eg, input logic [7:0] eh, input logic [7:0] el);
    logic [11:0] mvt [4];
    mvt = '{12'd3100, 12'd3200, 12'd3350, 12'd3500};
    @(negedge clk_sys_in);
    check(rx_mute, eg[3:2] == 2'b11);
    if (eg[3:2] != 2'b11) check(rx_db, 32'd6 * eg[3:2]);
    check(tx_mute, eg[1:0] == 2'b11);
    if (eg[1:0] != 2'b11) check(tx_db, 32'd18 + 32'd6 * eg[1:0]);
    check(spd, eh[5:4]);
    check(cap_en, eh[3]);
    check(cap_ma, eh[3] ? 32'd60 : 32'd0);
    check(rz, eh[2]);
    check(rt, eh[0]);
    check(lo_cv, eh[0] ? 32'd1935 : 32'd1350);
    check(hi_cv, eh[0] ? 32'd2365 : 32'd1650);
    check(mini, el[7:6]);
    check(mini_ma, 32'd10 + 32'd2 * el[7:6]);
    check(dcv, el[5:4]);
    check(mv, mvt[el[5:4]]);
    check(act, el[3:0]);
    check(real600, el[3:0] == 4'h0);
    check(cplx, el[3:0] == 4'h3);
    check(hready, 32'h1);
    check(hresp, 32'h0);
    @(posedge clk_sys_in);
  endtask

  task automatic reset_check();
    logic [31:0] rq;
    bus(`LIC_OFS_GAIN, 1'b0, 8'h00, rq);
    check(rq, 32'h0f);
    bus(`LIC_OFS_LOOP, 1'b0, 8'h00, rq);
    check(rq, 32'hf0);
    check(busy, 32'h0);
    check_out(8'h0f, 8'h00, 8'hf0);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // ordinary cases: write, read straight back, then the decoded figures
  lic_row_s rows [14] = '{
    '{`LIC_OFS_GAIN, 8'h00, 8'h00}, '{`LIC_OFS_GAIN, 8'h05, 8'h05},
    '{`LIC_OFS_GAIN, 8'hfa, 8'h0a}, '{`LIC_OFS_GAIN, 8'hf3, 8'h03},
    '{`LIC_OFS_HOOK, 8'hff, 8'h3f}, '{`LIC_OFS_HOOK, 8'h15, 8'h15},
    '{`LIC_OFS_HOOK, 8'h2a, 8'h2a}, '{`LIC_OFS_HOOK, 8'h00, 8'h00},
    '{`LIC_OFS_LOOP, 8'h00, 8'h00}, '{`LIC_OFS_LOOP, 8'h53, 8'h53},
    '{`LIC_OFS_LOOP, 8'ha5, 8'ha5}, '{`LIC_OFS_LOOP, 8'hff, 8'hff},
    '{12'h00c, 8'h5a, 8'h00}, '{12'hffc, 8'hc3, 8'h00}};

  initial begin
    rstn_in = 1'b0;
    hsel = 1'b1;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    err_count = 0;
    checked = 0;
    g = 8'h0f;
    h = 8'h00;
    l = 8'hf0;
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    reset_check();
    foreach (rows[i]) begin
      r = rows[i];
      bus(r.addr, 1'b1, r.wdata, q);
      case (r.addr)
        `LIC_OFS_GAIN: g = r.rdback;
        `LIC_OFS_HOOK: h = r.rdback;
        `LIC_OFS_LOOP: l = r.rdback;
        default: ;
      endcase
      bus(r.addr, 1'b0, 8'h00, q);
      check(q, {24'h0, r.rdback});
      check_out(g, h, l);
    end
    // release time per speed code, both codes with the upper bit set included
    for (int sp = 0; sp < 4; sp++) begin
      bus(`LIC_OFS_HOOK, 1'b1, {2'b00, sp[1:0], 4'h0}, q);
      w = 0;
      do begin
        @(negedge clk_sys_in);
        w++;
      end while (busy !== 1'b1 && w < 8);
      n = 0;
      while (busy === 1'b1 && n < 100) begin
        n++;
        @(negedge clk_sys_in);
      end
      check(n, sp == 0 ? FAST : (sp == 1 ? MID : SLOW));
      @(posedge clk_sys_in);
    end
    // second reset in mid-run, the clock after a hook write so its release never starts, and all fields but the AC termination code moved
    bus(`LIC_OFS_GAIN, 1'b1, 8'h00, q);
    bus(`LIC_OFS_LOOP, 1'b1, 8'h00, q);
    bus(`LIC_OFS_HOOK, 1'b1, 8'h3f, q);
    rstn_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    reset_check();
    end_of_test();
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_count++;
    end_of_test();
  end
endmodule
